// ---- vbo_pkg.sv ----
// package: shared constants and types for the vector bit-op and branch unit
// Behaviour
// - whole-vector move-if-clear: take source where mask bit 0, keep old where 1.
// - immediate move-if-clear: 8-bit mask repeated per byte lane, same selection.
// - vector bit invert flips one bit per element at low position bits.
// - immediate bit invert flips bit at immediate modulo element width everywhere.
// - formatted branch taken only when every element is nonzero.
// - one delay slot; target is delay slot address plus signed words times four.
// - whole-vector branch taken when any bit of tested vector is one.
// - bit choose: old dest bit 0 takes first source, 1 takes second.
// - immediate bit choose: old dest bit 0 takes source, 1 takes immediate bit.
// - vector bit force-one sets one bit per element at position modulo width.
// - immediate bit force-one sets bit at immediate position in every element.
// - only reserved-instruction or unit-disabled exceptions may be raised.
// - no operand-dependent exception; every operand gives a defined result.
// - element format selects byte, halfword, word or doubleword elements.
package vbo_pkg;
  localparam int VEC_W = 128;
  localparam int PC_W = 64;
  localparam int OFS_W = 16;
  localparam int INSN_BYTES_SHIFT = 2;
  localparam logic [PC_W-1:0] PC_RESET = 64'h0;
  localparam int LAT_CYCLES = 1;
  typedef enum logic [1:0] {
    VBO_FMT_B = 2'b00,
    VBO_FMT_H = 2'b01,
    VBO_FMT_W = 2'b10,
    VBO_FMT_D = 2'b11
  } vbo_fmt_t;
  typedef enum logic [3:0] {
    VBO_OP_NONE = 4'h0,
    VBO_OP_MOVZ = 4'h1,
    VBO_OP_MOVZI = 4'h2,
    VBO_OP_NEG = 4'h3,
    VBO_OP_NEGI = 4'h4,
    VBO_OP_SEL = 4'h5,
    VBO_OP_SELI = 4'h6,
    VBO_OP_SET = 4'h7,
    VBO_OP_SETI = 4'h8,
    VBO_OP_BNZ_FMT = 4'h9,
    VBO_OP_BRANCH_ANY_BIT_SET = 4'ha
  } vbo_op_t;
endpackage : vbo_pkg

// ---- vbo_lane_if.sv ----
// interface: operands and lane result between top and lane datapath
`timescale 1ns/1ps
interface vbo_lane_if;
  vbo_pkg::vbo_op_t op;
  vbo_pkg::vbo_fmt_t fmt;
  logic [vbo_pkg::VEC_W-1:0] src_a;
  logic [vbo_pkg::VEC_W-1:0] src_b;
  logic [vbo_pkg::VEC_W-1:0] dst_old;
  logic [7:0] imm;
  logic [5:0] bit_pos;
  logic [vbo_pkg::VEC_W-1:0] result;
  logic all_nonzero;
  logic any_set;
  modport top (output op, fmt, src_a, src_b, dst_old, imm, bit_pos,
               input result, all_nonzero, any_set);
  modport lane (input op, fmt, src_a, src_b, dst_old, imm, bit_pos,
                output result, all_nonzero, any_set);
endinterface : vbo_lane_if

// ---- vbo_lanes.sv ----
// module: combinational per-element datapath for all bit operations
`timescale 1ns/1ps
module vbo_lanes (
  vbo_lane_if.lane lif
);
  localparam int NB = vbo_pkg::VEC_W / 8;
  logic [vbo_pkg::VEC_W-1:0] onehot;
  logic [vbo_pkg::VEC_W-1:0] imm_rep;
  logic [NB-1:0] byte_nz;

  // per-byte position mask, immediate replication and zero tests
  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_byte
      logic [5:0] pos;
      logic [5:0] base;
      logic [5:0] ofs;
      logic [7:0] oh;
      always_comb begin
        pos = lif.bit_pos;
        base = 6'h0;
        unique case (lif.fmt)
          vbo_pkg::VBO_FMT_B: begin
            pos = {3'h0, lif.src_b[8*g +: 3]};
            base = 6'h0;
          end
          vbo_pkg::VBO_FMT_H: begin
            pos = {2'h0, lif.src_b[16*(g/2) +: 4]};
            base = 6'(8*(g%2));
          end
          vbo_pkg::VBO_FMT_W: begin
            pos = {1'h0, lif.src_b[32*(g/4) +: 5]};
            base = 6'(8*(g%4));
          end
          vbo_pkg::VBO_FMT_D: begin
            pos = lif.src_b[64*(g/8) +: 6];
            base = 6'(8*(g%8));
          end
        endcase
        if (lif.op == vbo_pkg::VBO_OP_NEGI || lif.op == vbo_pkg::VBO_OP_SETI) begin
          unique case (lif.fmt)
            vbo_pkg::VBO_FMT_B: pos = {3'h0, lif.bit_pos[2:0]};
            vbo_pkg::VBO_FMT_H: pos = {2'h0, lif.bit_pos[3:0]};
            vbo_pkg::VBO_FMT_W: pos = {1'h0, lif.bit_pos[4:0]};
            vbo_pkg::VBO_FMT_D: pos = lif.bit_pos;
          endcase
        end
        ofs = pos - base;
        oh = (pos >= base && ofs < 6'h8) ? 8'(8'h1 << ofs[2:0]) : 8'h0;
      end
      // each byte slice of the position mask has its own driver
      assign onehot[8*g +: 8] = oh;
      assign imm_rep[8*g +: 8] = lif.imm;
      assign byte_nz[g] = |lif.src_b[8*g +: 8];
    end
  endgenerate

  // element nonzero test at selected format
  always_comb begin
    lif.all_nonzero = 1'b1;
    for (int e = 0; e < NB; e++) begin
      unique case (lif.fmt)
        vbo_pkg::VBO_FMT_B: if (!byte_nz[e]) lif.all_nonzero = 1'b0;
        vbo_pkg::VBO_FMT_H: if (e % 2 == 0 && byte_nz[e +: 2] == 2'h0) lif.all_nonzero = 1'b0;
        vbo_pkg::VBO_FMT_W: if (e % 4 == 0 && byte_nz[e +: 4] == 4'h0) lif.all_nonzero = 1'b0;
        vbo_pkg::VBO_FMT_D: if (e % 8 == 0 && byte_nz[e +: 8] == 8'h0) lif.all_nonzero = 1'b0;
      endcase
    end
  end

  assign lif.any_set = |lif.src_b;

  // result select; every operand yields a defined value
  always_comb begin
    unique case (lif.op)
      vbo_pkg::VBO_OP_MOVZ: lif.result = (lif.src_a & ~lif.src_b) | (lif.dst_old & lif.src_b);
      vbo_pkg::VBO_OP_MOVZI: lif.result = (lif.src_a & ~imm_rep) | (lif.dst_old & imm_rep);
      vbo_pkg::VBO_OP_NEG, vbo_pkg::VBO_OP_NEGI: lif.result = lif.src_a ^ onehot;
      vbo_pkg::VBO_OP_SEL: lif.result = (lif.src_a & ~lif.dst_old) | (lif.src_b & lif.dst_old);
      vbo_pkg::VBO_OP_SELI: lif.result = (lif.src_a & ~lif.dst_old) | (imm_rep & lif.dst_old);
      vbo_pkg::VBO_OP_SET, vbo_pkg::VBO_OP_SETI: lif.result = lif.src_a | onehot;
      default: lif.result = lif.dst_old;
    endcase
  end
endmodule : vbo_lanes

// ---- vbo_unit.sv ----
// module: top of vector bit-op and branch execution unit
`timescale 1ns/1ps
module vbo_unit (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire logic [3:0] issue_op,
  input wire logic [1:0] element_format,
  input wire logic [vbo_pkg::VEC_W-1:0] first_source_vector,
  input wire logic [vbo_pkg::VEC_W-1:0] second_source_vector,
  input wire logic [vbo_pkg::VEC_W-1:0] dest_vector,
  input wire logic [7:0] byte_immediate,
  input wire logic [5:0] bit_position_imm,
  input wire logic [vbo_pkg::OFS_W-1:0] branch_word_offset,
  input wire logic [vbo_pkg::PC_W-1:0] delay_slot_pc,
  input wire logic unit_enabled,
  output logic wb_valid,
  output logic [vbo_pkg::VEC_W-1:0] wb_data,
  output logic branch_valid,
  output logic branch_taken,
  output logic [vbo_pkg::PC_W-1:0] branch_target,
  output logic exc_reserved,
  output logic exc_unit_disabled
);
  vbo_lane_if lif ();
  vbo_pkg::vbo_op_t op_in;
  logic op_legal;
  logic is_branch;
  logic [vbo_pkg::PC_W-1:0] target_comb;
  logic wb_valid_reg, wb_valid_next;
  logic [vbo_pkg::VEC_W-1:0] wb_data_reg, wb_data_next;
  logic branch_valid_reg, branch_valid_next;
  logic branch_taken_reg, branch_taken_next;
  logic [vbo_pkg::PC_W-1:0] branch_target_reg, branch_target_next;
  logic exc_reserved_reg, exc_reserved_next;
  logic exc_disabled_reg, exc_disabled_next;

  // decode of incoming op
  assign op_in = vbo_pkg::vbo_op_t'(issue_op);
  assign op_legal = (issue_op >= 4'h1) && (issue_op <= 4'ha);
  assign is_branch = (op_in == vbo_pkg::VBO_OP_BNZ_FMT) || (op_in == vbo_pkg::VBO_OP_BRANCH_ANY_BIT_SET);

  // operands to lane datapath; dest is the pre-instruction value
  // old destination operand
  assign lif.op = op_legal ? op_in : vbo_pkg::VBO_OP_NONE;
  assign lif.fmt = vbo_pkg::vbo_fmt_t'(element_format);
  assign lif.src_a = first_source_vector;
  assign lif.src_b = second_source_vector;
  assign lif.dst_old = dest_vector;
  assign lif.imm = byte_immediate;
  assign lif.bit_pos = bit_position_imm;

  vbo_lanes u_lanes (
    .lif(lif.lane)
  );

  assign target_comb = delay_slot_pc + vbo_pkg::PC_W'({{(vbo_pkg::PC_W-vbo_pkg::OFS_W){
    branch_word_offset[vbo_pkg::OFS_W-1]}}, branch_word_offset} << vbo_pkg::INSN_BYTES_SHIFT);

  // next-state for the single result stage
  always_comb begin
    wb_valid_next = 1'b0;
    wb_data_next = wb_data_reg;
    branch_valid_next = 1'b0;
    branch_taken_next = 1'b0;
    branch_target_next = branch_target_reg;
    exc_reserved_next = 1'b0;
    exc_disabled_next = 1'b0;
    if (issue_valid) begin
      if (!unit_enabled) begin
        exc_disabled_next = 1'b1;
      end else if (!op_legal) begin
        exc_reserved_next = 1'b1;
      end else if (is_branch) begin
        branch_valid_next = 1'b1;
        branch_target_next = target_comb;
        branch_taken_next = (op_in == vbo_pkg::VBO_OP_BNZ_FMT) ? lif.all_nonzero : lif.any_set;
      end else begin
        wb_valid_next = 1'b1;
        wb_data_next = lif.result;
      end
    end
  end

  // result stage registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_valid_reg <= 1'b0;
      wb_data_reg <= '0;
      branch_valid_reg <= 1'b0;
      branch_taken_reg <= 1'b0;
      branch_target_reg <= vbo_pkg::PC_RESET;
      exc_reserved_reg <= 1'b0;
      exc_disabled_reg <= 1'b0;
    end else begin
      wb_valid_reg <= wb_valid_next;
      wb_data_reg <= wb_data_next;
      branch_valid_reg <= branch_valid_next;
      branch_taken_reg <= branch_taken_next;
      branch_target_reg <= branch_target_next;
      exc_reserved_reg <= exc_reserved_next;
      exc_disabled_reg <= exc_disabled_next;
    end
  end

  assign wb_valid = wb_valid_reg;
  assign wb_data = wb_data_reg;
  assign branch_valid = branch_valid_reg;
  assign branch_taken = branch_taken_reg;
  assign branch_target = branch_target_reg;
  assign exc_reserved = exc_reserved_reg;
  assign exc_unit_disabled = exc_disabled_reg;

  // checks on the result stage
  property p_movz;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_MOVZ) |=> wb_valid &&
      wb_data == (($past(first_source_vector) & ~$past(second_source_vector)) |
                  ($past(dest_vector) & $past(second_source_vector)));
  endproperty
  a_movz: assert property (p_movz) else $error("move-if-clear result wrong");
  property p_movzi;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_MOVZI) |=>
      wb_data == (($past(first_source_vector) & ~{(vbo_pkg::VEC_W/8){$past(byte_immediate)}}) |
                  ($past(dest_vector) & {(vbo_pkg::VEC_W/8){$past(byte_immediate)}}));
  endproperty
  a_movzi: assert property (p_movzi) else $error("imm move-if-clear wrong");
  property p_negi_b;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_NEGI &&
     element_format == 2'h0) |=>
      (wb_data[7:0] ^ $past(first_source_vector[7:0])) == 8'(8'h1 << $past(bit_position_imm[2:0]));
  endproperty
  a_negi_b: assert property (p_negi_b) else $error("imm invert wrong bit");
  property p_neg_b;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_NEG && element_format == 2'h0) |=>
      (wb_data[15:8] ^ $past(first_source_vector[15:8])) ==
        8'(8'h1 << $past(second_source_vector[10:8]));
  endproperty
  a_neg_b: assert property (p_neg_b) else $error("vector invert wrong bit");
  property p_sel;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_SEL) |=>
      wb_data == (($past(first_source_vector) & ~$past(dest_vector)) |
                  ($past(second_source_vector) & $past(dest_vector)));
  endproperty
  a_sel: assert property (p_sel) else $error("bit choose wrong");
  property p_set_d;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_SET && element_format == 2'h3) |=>
      wb_data[63:0] == ($past(first_source_vector[63:0]) |
                        (64'h1 << $past(second_source_vector[5:0])));
  endproperty
  a_set_d: assert property (p_set_d) else $error("force-one wrong");
  property p_bnzv;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_BRANCH_ANY_BIT_SET) |=>
      branch_valid && branch_taken == ($past(second_source_vector) != '0);
  endproperty
  a_bnzv: assert property (p_bnzv) else $error("any-bit branch wrong");
  property p_target;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && is_branch) |=>
      branch_target - $past(delay_slot_pc) ==
        vbo_pkg::PC_W'($signed($past(branch_word_offset))) * 64'h4;
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");
  property p_disabled;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && !unit_enabled) |=> exc_unit_disabled && !wb_valid && !branch_valid;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled unit wrote");
  property p_no_data_exc;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_legal) |=> !exc_reserved && !exc_unit_disabled &&
      (wb_valid || branch_valid);
  endproperty
  a_no_data_exc: assert property (p_no_data_exc) else $error("legal op faulted");
  property p_seli;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_SELI) |=>
      wb_data == (($past(first_source_vector) & ~$past(dest_vector)) |
                  ({(vbo_pkg::VEC_W/8){$past(byte_immediate)}} & $past(dest_vector)));
  endproperty
  a_seli: assert property (p_seli) else $error("imm bit choose wrong");
  property p_seti_w;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_SETI &&
     element_format == 2'h2) |=>
      wb_data[31:0] == ($past(first_source_vector[31:0]) |
                        (32'h1 << $past(bit_position_imm[4:0])));
  endproperty
  a_seti_w: assert property (p_seti_w) else $error("imm force-one wrong");
  property p_bnz_d;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && op_in == vbo_pkg::VBO_OP_BNZ_FMT &&
     element_format == 2'h3) |=> branch_valid &&
      branch_taken == (($past(second_source_vector[63:0]) != 64'h0) &&
                       ($past(second_source_vector[127:64]) != 64'h0));
  endproperty
  a_bnz_d: assert property (p_bnz_d) else $error("all-element branch wrong");
  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_n)
    (issue_valid && unit_enabled && !op_legal) |=> exc_reserved && !wb_valid && !branch_valid;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved op not flagged");
  property p_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
    !issue_valid |=> !wb_valid && !branch_valid && !exc_reserved && !exc_unit_disabled;
  endproperty
  a_quiet: assert property (p_quiet) else $error("result without issue");
  c_bnz_taken: cover property (@(posedge ref_clk) disable iff (!rst_n)
    branch_valid && branch_taken);
  c_bnz_fall: cover property (@(posedge ref_clk) disable iff (!rst_n)
    branch_valid && !branch_taken);
  c_wb: cover property (@(posedge ref_clk) disable iff (!rst_n) wb_valid ##1 wb_valid);
  c_rsvd: cover property (@(posedge ref_clk) disable iff (!rst_n) exc_reserved);
endmodule : vbo_unit

// ---- vbo_core_model.sv ----
// partner: core issue stage and register file read side feeding the unit
`timescale 1ns/1ps
module vbo_core_model (
  input wire logic ref_clk,
  output logic issue_valid,
  output logic [3:0] issue_op,
  output logic [1:0] element_format,
  output logic [vbo_pkg::VEC_W-1:0] first_source_vector,
  output logic [vbo_pkg::VEC_W-1:0] second_source_vector,
  output logic [vbo_pkg::VEC_W-1:0] dest_vector,
  output logic [7:0] byte_immediate,
  output logic [5:0] bit_position_imm,
  output logic [vbo_pkg::OFS_W-1:0] branch_word_offset,
  output logic [vbo_pkg::PC_W-1:0] delay_slot_pc,
  output logic unit_enabled
);
  // quiet operands at time zero
  initial begin
    issue_valid = 1'b0;
    issue_op = 4'h0;
    element_format = 2'h0;
    first_source_vector = '0;
    second_source_vector = '0;
    dest_vector = '0;
    byte_immediate = 8'h00;
    bit_position_imm = 6'h00;
    branch_word_offset = 16'h0000;
    delay_slot_pc = 64'h0;
    unit_enabled = 1'b1;
  end
  // one instruction per slot
  // offer one instruction; held until the next falling edge
  task automatic issue(logic [3:0] o, logic [1:0] f, logic [127:0] a, logic [127:0] b,
                       logic [127:0] d, logic [7:0] imm, logic [5:0] pos, logic [15:0] ofs,
                       logic [63:0] pc, logic en);
    @(negedge ref_clk);
    issue_valid = 1'b1;
    issue_op = o;
    element_format = f;
    first_source_vector = a;
    second_source_vector = b;
    dest_vector = d;
    byte_immediate = imm;
    bit_position_imm = pos;
    branch_word_offset = ofs;
    delay_slot_pc = pc;
    unit_enabled = en;
  endtask : issue
  // idle slot: the three vector operand lines no longer hold the last value
  task automatic idle();
    @(negedge ref_clk);
    issue_valid = 1'b0;
    first_source_vector = ~first_source_vector;
    second_source_vector = ~second_source_vector;
    dest_vector = ~dest_vector;
  endtask : idle
endmodule : vbo_core_model

// ---- vector_bit_ops_and_branch_tb_top.sv ----
// testbench: random instruction stream against a bit-level reference
`timescale 1ns/1ps
module vector_bit_ops_and_branch_tb_top;
  typedef struct {
    logic [3:0] kind;
    logic [127:0] data;
    logic taken;
    logic [63:0] tgt;
  } vbo_exp_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic issue_valid, unit_enabled, wb_valid, branch_valid, branch_taken;
  logic exc_reserved, exc_unit_disabled;
  logic [3:0] issue_op;
  logic [1:0] element_format;
  logic [127:0] first_source_vector, second_source_vector, dest_vector, wb_data;
  logic [7:0] byte_immediate;
  logic [5:0] bit_position_imm;
  logic [15:0] branch_word_offset;
  logic [63:0] delay_slot_pc, branch_target;
  int mismatches = 0;
  int n_tests = 0;
  vbo_exp_t exp_q[$];
  vbo_core_model i_vbo_core_model (.*);
  vbo_unit i_vbo_unit (.*);
  // clock
  always #5 ref_clk = ~ref_clk;
  // compare and count
  task automatic check(logic [127:0] got, logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // reference result of one instruction
  function automatic vbo_exp_t calc(logic [3:0] op, logic [1:0] fmt, logic [127:0] a,
      logic [127:0] b, logic [127:0] d, logic [7:0] imm, logic [5:0] pos, logic [15:0] ofs,
      logic [63:0] pc, logic en);
    vbo_exp_t e;
    int w;
    int p;
    w = 8 << fmt;
    e.kind = 4'h1;
    e.data = '0;
    e.tgt = pc + {{46{ofs[15]}}, ofs, 2'b00};
    e.taken = (op == 4'h9) ? 1'b1 : |b;
    for (int j = 0; j < 128 / w; j++) if (((b >> (j * w)) & ((128'h1 << w) - 1)) == 0) e.taken = 1'b0;
    if (op != 4'h9) e.taken = |b;
    for (int k = 0; k < 128; k++) begin
      p = (op == 4'h4 || op == 4'h8) ? pos % w : b[(k / w) * w +: 6] % w;
      case (op)
        4'h1: e.data[k] = b[k] ? d[k] : a[k];
        4'h2: e.data[k] = imm[k % 8] ? d[k] : a[k];
        4'h3, 4'h4: e.data[k] = a[k] ^ (k % w == p);
        4'h5: e.data[k] = d[k] ? b[k] : a[k];
        4'h6: e.data[k] = d[k] ? imm[k % 8] : a[k];
        4'h7, 4'h8: e.data[k] = a[k] | (k % w == p);
        default: ;
      endcase
    end
    if (op == 4'h9 || op == 4'ha) e.kind = 4'h2;
    if (op == 4'h0 || op > 4'ha) e.kind = 4'h4;
    if (!en) e.kind = 4'h8;
    return e;
  endfunction : calc
  // random operands, noted then offered, sometimes with a gap
  task automatic send(int o, int f, logic en);
    logic [127:0] a, b, d;
    logic [63:0] pc;
    logic [15:0] ofs;
    logic [7:0] imm;
    logic [5:0] pos;
    int r;
    a = {$urandom, $urandom, $urandom, $urandom};
    b = {$urandom, $urandom, $urandom, $urandom};
    d = {$urandom, $urandom, $urandom, $urandom};
    pc = {$urandom, $urandom};
    ofs = 16'($urandom);
    imm = 8'($urandom);
    pos = 6'($urandom);
    r = $urandom % 3;
    if (r == 0) b = b & ~(((128'h1 << (8 << f)) - 1) << (($urandom % (16 >> f)) * (8 << f)));
    if (r == 1) b = '0;
    if (r == 2 && o == 10) b = 128'h1 << ($urandom % 128);
    exp_q.push_back(calc(4'(o), 2'(f), a, b, d, imm, pos, ofs, pc, en));
    i_vbo_core_model.issue(4'(o), 2'(f), a, b, d, imm, pos, ofs, pc, en);
    if ($urandom % 4 == 0) i_vbo_core_model.idle();
  endtask : send
  // monitor: oldest note against each result
  always @(negedge ref_clk) begin
    vbo_exp_t e;
    if ({exc_unit_disabled, exc_reserved, branch_valid, wb_valid} !== 4'h0) begin
      if (exp_q.size() == 0) check(128'({exc_unit_disabled, exc_reserved, branch_valid, wb_valid}), 128'h0);
      else begin
        e = exp_q.pop_front();
        check(128'({exc_unit_disabled, exc_reserved, branch_valid, wb_valid}), 128'(e.kind));
        if (e.kind == 4'h1) check(wb_data, e.data);
        if (e.kind == 4'h2) check(128'(branch_taken), 128'(e.taken));
        if (e.kind == 4'h2 && e.taken) check(128'(branch_target), 128'(e.tgt));
      end
    end
  end
  // watchdog
  initial begin
    #50000;
    mismatches++;
    final_report();
  end
  // main sequence
  initial begin
    void'($urandom(69));
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int o = 1; o <= 10; o++) for (int f = 0; f < 4; f++) repeat (4) send(o, f, 1'b1);
    $display("test ops done");
    for (int o = 0; o < 16; o++) if (o == 0 || o > 10) send(o, 0, 1'b1);
    for (int o = 0; o < 16; o++) send(o, o % 4, 1'b0);
    $display("test exceptions done");
    repeat (3) i_vbo_core_model.idle();
    check(128'(exp_q.size()), 128'h0);
    final_report();
  end
endmodule : vector_bit_ops_and_branch_tb_top
